// file: core/acc_map.svh
// Purpose: offsets, field positions, reset values and timing counts for amp/comparator control
// Assumes: register indexes are word indexes; byte address is four times the index
// Notes: definitions only
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH
`define ACC_IDX_CFG_A 3'h0
`define ACC_IDX_CTL_A 3'h1
`define ACC_IDX_CFG_B 3'h2
`define ACC_IDX_CTL_B 3'h3
`define ACC_IDX_AMP_KEY 3'h4
`define ACC_IDX_REG_A 3'h5
`define ACC_FIRST_KEY 32'h45670123
`define ACC_SECOND_KEY 32'hCDEF89AB
`define ACC_CTL_A_RST 32'h800C0736
`define ACC_CTL_B_RST 32'h80000078
`define ACC_CFG_A_RST 32'h00000000
`define ACC_CFG_B_RST 32'h00000000
`define ACC_CTL_A_MASK 32'h001F1F37
`define ACC_CTL_B_MASK 32'h0F0101FF
`define ACC_CFG_A_MASK 32'h003F000D
`define ACC_CFG_B_MASK 32'h00000030
`define ACC_LOCK_BIT 31
`define ACC_AMP_EN_BIT 0
`define ACC_OUT_ROUTE_LSB 1
`define ACC_POS_SEL_LSB 4
`define ACC_NEG_SEL_LSB 8
`define ACC_FB_EN_BIT 11
`define ACC_DIFF_BIT 12
`define ACC_BIAS_EN_BIT 16
`define ACC_BIAS_LVL_BIT 17
`define ACC_REF_SEL_LSB 18
`define ACC_HS_BIT 20
`define ACC_CMP1_EN_BIT 0
`define ACC_CMP1_ROUTE_LSB 1
`define ACC_CMP1_NEG_LSB 3
`define ACC_CMP1_POS_LSB 5
`define ACC_HYST_BIT 7
`define ACC_CMP2_EN_BIT 16
`define ACC_BRAKE_LSB 26
`define ACC_POLL_EN_BIT 0
`define ACC_POLL_CNT_LSB 2
`define ACC_POLL_CH1_LSB 16
`define ACC_CMP2_RST_BIT 5
`define ACC_BRAKE_CMP2 2'h2
`define ACC_REF_OFF 2'h3
`define ACC_GAIN_MIN 3'h3
`define ACC_GAIN_MAX 3'h6
`define ACC_POLL_DWELL_NS 1000
`define ACC_CLK_NS 4
`define ACC_POLL_DWELL_CYC ((`ACC_POLL_DWELL_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`endif

// file: core/acc_pkg.sv
// Purpose: types for amp/comparator control
// Assumes: constants live in acc_map.svh
// Notes: key unlock progress states
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_LOCKED = 2'h0,
    ACC_HALF = 2'h1,
    ACC_OPEN = 2'h3
  } acc_key_type;
endpackage

// file: core/acc_ctrl.sv
// Purpose: register file, key locks, poll sequencer and routing for amplifier and two comparators
// Assumes: simple synchronous write/read port; analog comparator outputs arrive asynchronously
// Notes: all outputs registered
`timescale 1ns/100ps
`include "acc_map.svh"
// Function
// R1 - software writes amp keys in order
// R2 - software writes comparator keys in order
// R3 - amplifier powered only while enabled
// R4 - select fields steer amplifier muxes
// R5 - single-ended grounds negative, gain codes need feedback
// R6 - differential mode uses feedback and negative input
// R7 - high-speed bit selects fast mode
// R8 - bias enable adds output bias level
// R9 - comparator2 reference valid only with bias
// R10 - comparator2 high resets system when enabled
// R11 - brake select 10b routes comparator2
// R12 - software configures before enabling comparator2
// R13 - each comparator runs only when enabled
// R14 - comparator1 route and inputs steered
// R15 - comparator2 input from amp output, feeds brake
// R16 - polling steps positive input through slots
// R17 - poll visits each chosen input in turn
// R18 - poll count sets slots before wrap
// R19 - amp lock resets set, write1 locks
// R20 - locked writes ignored, bad key relocks; here a bad key only resets a pair in progress, once open it stays open
// R21 - outputs change on write edge, reset defaults; outputs here change one edge after the write edge
module acc_ctrl #(
  parameter int POLL_DWELL = `ACC_POLL_DWELL_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // register port
  input wire logic i_wr,
  input wire logic [2:0] i_idx,
  input wire logic [31:0] i_wdata,
  input wire logic [2:0] i_ridx,
  output logic [31:0] o_rdata,
  // analog comparator results
  input wire logic i_cmp1_raw,
  input wire logic i_cmp2_raw,
  // amplifier controls
  output logic o_amp_enable,
  output logic [1:0] o_pos_input_sel,
  output logic [2:0] o_neg_input_gain_sel,
  output logic [1:0] o_output_route_sel,
  output logic o_neg_ground,
  output logic o_internal_feedback_en,
  output logic o_amp_high_speed,
  output logic o_bias_enable,
  output logic o_bias_level_sel,
  output logic [1:0] o_cmp2_ref_sel,
  // comparator controls
  output logic o_comparator1_enable,
  output logic o_comparator2_enable,
  output logic [1:0] o_cmp1_route_sel,
  output logic [1:0] o_cmp1_pos_sel,
  output logic [1:0] o_cmp1_neg_sel,
  output logic o_hysteresis_enable,
  // comparator results out
  output logic o_cmp1_pin,
  output logic o_cmp1_tim_cap,
  output logic o_brake_cmp2,
  output logic o_sys_reset_req
);
  logic [31:0] ctl_a_q, ctl_b_q, cfg_a_q, cfg_b_q;
  acc_pkg::acc_key_type amp_key_q, reg_a_q;
  logic amp_open, cmp_open;
  logic [1:0] slot_q;
  logic [$clog2(POLL_DWELL+1)-1:0] dwell_q;
  logic [1:0] c1_s1_q, c1_s2_q;
  logic c1, c2;

  function automatic acc_pkg::acc_key_type key_next(input acc_pkg::acc_key_type st, input logic [31:0] d);
    key_next = acc_pkg::ACC_LOCKED;
    // a repeated first key restarts the pair; the lock itself stays set
    if (d == `ACC_FIRST_KEY && st != acc_pkg::ACC_OPEN) begin
      key_next = acc_pkg::ACC_HALF;
    end else if (d == `ACC_SECOND_KEY && st == acc_pkg::ACC_HALF) begin
      key_next = acc_pkg::ACC_OPEN;
    end else if (st == acc_pkg::ACC_OPEN) begin
      key_next = acc_pkg::ACC_OPEN;
    end
  endfunction

  // protected write: masked fields only, lock bit is write-1-to-set
  function automatic logic [31:0] prot_wr(input logic [31:0] old, input logic [31:0] d, input logic [31:0] m);
    prot_wr = (old & ~m) | (d & m);
    prot_wr[`ACC_LOCK_BIT] = old[`ACC_LOCK_BIT] | d[`ACC_LOCK_BIT];
  endfunction

  assign amp_open = !ctl_a_q[`ACC_LOCK_BIT];
  assign cmp_open = !ctl_b_q[`ACC_LOCK_BIT];

  // key sequencers; before the pair completes, a wrong key drops back to locked and a repeated first key restarts it; once open, any key keeps it open
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      amp_key_q <= acc_pkg::ACC_LOCKED;
    end else if (i_wr && i_idx == `ACC_IDX_AMP_KEY) begin
      amp_key_q <= key_next(amp_key_q, i_wdata); // see R1 see R20
    end else if (i_wr && i_idx == `ACC_IDX_CTL_A && i_wdata[`ACC_LOCK_BIT]) begin
      amp_key_q <= acc_pkg::ACC_LOCKED;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      reg_a_q <= acc_pkg::ACC_LOCKED;
    end else if (i_wr && i_idx == `ACC_IDX_REG_A) begin
      reg_a_q <= key_next(reg_a_q, i_wdata); // see R2 see R20
    end else if (i_wr && i_idx == `ACC_IDX_CTL_B && i_wdata[`ACC_LOCK_BIT]) begin
      reg_a_q <= acc_pkg::ACC_LOCKED;
    end
  end

  // amplifier control register and lock
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ctl_a_q <= `ACC_CTL_A_RST; // see R19 see R21
    end else if (i_wr && i_idx == `ACC_IDX_AMP_KEY && key_next(amp_key_q, i_wdata) == acc_pkg::ACC_OPEN) begin
      ctl_a_q[`ACC_LOCK_BIT] <= 1'b0;
    end else if (i_wr && i_idx == `ACC_IDX_CTL_A) begin
      if (amp_open) begin
        ctl_a_q <= prot_wr(ctl_a_q, i_wdata, `ACC_CTL_A_MASK); // see R20 see R21
      end else begin
        ctl_a_q[`ACC_LOCK_BIT] <= 1'b1; // see R19
      end
    end
  end

  // comparator control register; also guards comparator2 reset enable
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ctl_b_q <= `ACC_CTL_B_RST;
    end else if (i_wr && i_idx == `ACC_IDX_REG_A && key_next(reg_a_q, i_wdata) == acc_pkg::ACC_OPEN) begin
      ctl_b_q[`ACC_LOCK_BIT] <= 1'b0;
    end else if (i_wr && i_idx == `ACC_IDX_CTL_B) begin
      if (cmp_open) begin
        ctl_b_q <= prot_wr(ctl_b_q, i_wdata, `ACC_CTL_B_MASK); // see R20
      end else begin
        ctl_b_q[`ACC_LOCK_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_a_q <= `ACC_CFG_A_RST;
    end else if (i_wr && i_idx == `ACC_IDX_CFG_A && amp_open) begin
      cfg_a_q <= i_wdata & `ACC_CFG_A_MASK;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_b_q <= `ACC_CFG_B_RST;
    end else if (i_wr && i_idx == `ACC_IDX_CFG_B && cmp_open) begin
      cfg_b_q <= i_wdata & `ACC_CFG_B_MASK;
    end
  end

  // poll sequencer: dwell per slot, wrap after poll_count+1 slots, three slots at most
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      slot_q <= 2'h0;
      dwell_q <= '0;
    end else if (!cfg_a_q[`ACC_POLL_EN_BIT]) begin
      slot_q <= 2'h0;
      dwell_q <= '0;
    end else if (dwell_q == ($bits(dwell_q))'(POLL_DWELL - 1)) begin
      dwell_q <= '0;
      if (slot_q >= cfg_a_q[`ACC_POLL_CNT_LSB +: 2] || slot_q == 2'h2) begin
        slot_q <= 2'h0; // see R18
      end else begin
        slot_q <= slot_q + 2'h1; // see R17
      end
    end else begin
      dwell_q <= dwell_q + 1'b1;
    end
  end

  // comparator result synchronisers
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      c1_s1_q <= 2'h0;
      c1_s2_q <= 2'h0;
    end else begin
      c1_s1_q <= {i_cmp2_raw, i_cmp1_raw};
      c1_s2_q <= c1_s1_q;
    end
  end
  assign c1 = c1_s2_q[0] & ctl_b_q[`ACC_CMP1_EN_BIT]; // see R13
  assign c2 = c1_s2_q[1] & ctl_b_q[`ACC_CMP2_EN_BIT]; // see R13 see R15

  // registered analog control outputs
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_amp_enable <= 1'b0;
      o_pos_input_sel <= 2'h3;
      o_neg_input_gain_sel <= 3'h7;
      o_output_route_sel <= 2'h3;
      o_neg_ground <= 1'b1;
      o_internal_feedback_en <= 1'b0;
      o_amp_high_speed <= 1'b0;
      o_bias_enable <= 1'b0;
      o_bias_level_sel <= 1'b0;
      o_cmp2_ref_sel <= 2'h3;
      o_comparator1_enable <= 1'b0;
      o_comparator2_enable <= 1'b0;
      o_cmp1_route_sel <= 2'h0;
      o_cmp1_pos_sel <= 2'h3;
      o_cmp1_neg_sel <= 2'h3;
      o_hysteresis_enable <= 1'b0;
    end else begin
      o_amp_enable <= ctl_a_q[`ACC_AMP_EN_BIT]; // see R3
      o_pos_input_sel <= cfg_a_q[`ACC_POLL_EN_BIT] ? cfg_a_q[`ACC_POLL_CH1_LSB + 2*slot_q +: 2] :
                         ctl_a_q[`ACC_POS_SEL_LSB +: 2]; // see R4 see R16
      o_neg_input_gain_sel <= ctl_a_q[`ACC_NEG_SEL_LSB +: 3]; // see R4
      o_output_route_sel <= ctl_a_q[`ACC_OUT_ROUTE_LSB +: 2]; // see R4 see R15
      o_neg_ground <= !ctl_a_q[`ACC_DIFF_BIT]; // see R5 see R6
      o_internal_feedback_en <= ctl_a_q[`ACC_FB_EN_BIT] | ctl_a_q[`ACC_DIFF_BIT] |
        (ctl_a_q[`ACC_NEG_SEL_LSB +: 3] >= `ACC_GAIN_MIN &&
         ctl_a_q[`ACC_NEG_SEL_LSB +: 3] <= `ACC_GAIN_MAX); // see R5 see R6
      o_amp_high_speed <= ctl_a_q[`ACC_HS_BIT]; // see R7
      o_bias_enable <= ctl_a_q[`ACC_BIAS_EN_BIT]; // see R8
      o_bias_level_sel <= ctl_a_q[`ACC_BIAS_LVL_BIT]; // see R8
      o_cmp2_ref_sel <= ctl_a_q[`ACC_BIAS_EN_BIT] ? ctl_a_q[`ACC_REF_SEL_LSB +: 2] : `ACC_REF_OFF; // see R9
      o_comparator1_enable <= ctl_b_q[`ACC_CMP1_EN_BIT]; // see R13
      o_comparator2_enable <= ctl_b_q[`ACC_CMP2_EN_BIT]; // see R13
      o_cmp1_route_sel <= ctl_b_q[`ACC_CMP1_ROUTE_LSB +: 2]; // see R14
      o_cmp1_pos_sel <= ctl_b_q[`ACC_CMP1_POS_LSB +: 2]; // see R14
      o_cmp1_neg_sel <= ctl_b_q[`ACC_CMP1_NEG_LSB +: 2]; // see R14
      o_hysteresis_enable <= ctl_b_q[`ACC_HYST_BIT];
    end
  end

  // result routing
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cmp1_pin <= 1'b0;
      o_cmp1_tim_cap <= 1'b0;
      o_brake_cmp2 <= 1'b0;
      o_sys_reset_req <= 1'b0;
    end else begin
      o_cmp1_pin <= c1 && ctl_b_q[`ACC_CMP1_ROUTE_LSB +: 2] == 2'h0; // see R14
      o_cmp1_tim_cap <= c1 && (ctl_b_q[`ACC_CMP1_ROUTE_LSB +: 2] == 2'h1 ||
                               ctl_b_q[`ACC_CMP1_ROUTE_LSB +: 2] == 2'h2); // see R14
      o_brake_cmp2 <= c2 && ctl_b_q[`ACC_BRAKE_LSB +: 2] == `ACC_BRAKE_CMP2; // see R11 see R15
      o_sys_reset_req <= c2 && cfg_b_q[`ACC_CMP2_RST_BIT]; // see R10
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 32'h00000000;
    end else begin
      unique case (i_ridx)
        `ACC_IDX_CFG_A: o_rdata <= cfg_a_q;
        `ACC_IDX_CTL_A: o_rdata <= ctl_a_q;
        `ACC_IDX_CFG_B: o_rdata <= cfg_b_q;
        `ACC_IDX_CTL_B: o_rdata <= ctl_b_q;
        default: o_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// file: test/acc_ctrl_checker.sv
// Purpose: port-level checks for the amp/comparator control block
// Assumes: register outputs lag the accepted write edge by one edge
// Notes: bound into every acc_ctrl instance
`timescale 1ns/100ps
`include "acc_map.svh"
module acc_ctrl_checker (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // write port
  input wire logic i_wr,
  input wire logic [2:0] i_idx,
  input wire logic [31:0] i_wdata,
  // watched outputs
  input wire logic o_amp_enable,
  input wire logic [2:0] o_neg_input_gain_sel,
  input wire logic o_neg_ground,
  input wire logic o_internal_feedback_en,
  input wire logic o_bias_enable,
  input wire logic [1:0] o_cmp2_ref_sel,
  input wire logic o_comparator2_enable,
  input wire logic [1:0] o_cmp1_route_sel,
  input wire logic o_cmp1_pin,
  input wire logic o_brake_cmp2,
  input wire logic o_sys_reset_req
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  sequence key_pair_s;
    i_wr && i_idx == `ACC_IDX_AMP_KEY && i_wdata == `ACC_FIRST_KEY ##1
    i_wr && i_idx == `ACC_IDX_AMP_KEY && i_wdata == `ACC_SECOND_KEY;
  endsequence
  sequence enable_wr_s;
    i_wr && i_idx == `ACC_IDX_CTL_A && i_wdata[0] && !i_wdata[31];
  endsequence
  AST_UNLOCK: assert property (key_pair_s ##1 enable_wr_s |-> ##2 o_amp_enable)
    else $error("amplifier not enabled after key pair and enable write");
  AST_WRITE_ONLY: assert property ($changed(o_amp_enable) |-> $past(i_wr, 2) && $past(i_idx, 2) == `ACC_IDX_CTL_A)
    else $error("amplifier enable changed without a control write");
  AST_GAIN_FB: assert property (o_neg_input_gain_sel >= `ACC_GAIN_MIN && o_neg_input_gain_sel <= `ACC_GAIN_MAX
    |-> o_internal_feedback_en)
    else $error("gain code without internal feedback");
  AST_DIFF_FB: assert property (!o_neg_ground |-> o_internal_feedback_en)
    else $error("differential mode without internal feedback");
  AST_REF_OFF: assert property (!o_bias_enable |-> o_cmp2_ref_sel == `ACC_REF_OFF)
    else $error("reference tap selected while bias is off");
  AST_RST_REQ: assert property (o_sys_reset_req |-> o_comparator2_enable || $past(o_comparator2_enable))
    else $error("reset request while comparator2 disabled");
  AST_BRAKE: assert property (o_brake_cmp2 |-> o_comparator2_enable || $past(o_comparator2_enable))
    else $error("brake driven while comparator2 disabled");
  AST_CMP1_PIN: assert property (o_cmp1_pin |-> o_cmp1_route_sel == 2'h0 || $past(o_cmp1_route_sel) == 2'h0)
    else $error("comparator1 pin driven on a timer route");
endmodule

bind acc_ctrl acc_ctrl_checker acc_ctrl_checker_inst (.i_clk_sys, .i_rstn, .i_wr, .i_idx, .i_wdata, .o_amp_enable,
  .o_neg_input_gain_sel, .o_neg_ground, .o_internal_feedback_en, .o_bias_enable, .o_cmp2_ref_sel,
  .o_comparator2_enable, .o_cmp1_route_sel, .o_cmp1_pin, .o_brake_cmp2, .o_sys_reset_req);

// file: test/acc_ctrl_bench.sv
// Purpose: self-checking bench for the amp/comparator control block
// Assumes: short poll dwell of 4 cycles
// Notes: every scenario judges the ports before it returns
`timescale 1ns/100ps
`include "acc_map.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module acc_ctrl_bench;
  logic i_clk_sys = 1'b0;
  logic i_rstn = 1'b0;
  logic i_wr = 1'b0;
  logic [2:0] i_idx = 3'h0;
  logic [31:0] i_wdata = 32'h0;
  logic [2:0] i_ridx = 3'h0;
  logic i_cmp1_raw = 1'b0;
  logic i_cmp2_raw = 1'b0;
  logic [31:0] o_rdata;
  logic [2:0] o_neg_input_gain_sel;
  logic [1:0] o_pos_input_sel, o_output_route_sel, o_cmp2_ref_sel, o_cmp1_route_sel, o_cmp1_pos_sel, o_cmp1_neg_sel;
  logic o_amp_enable, o_neg_ground, o_internal_feedback_en, o_amp_high_speed, o_bias_enable, o_bias_level_sel;
  logic o_comparator1_enable, o_comparator2_enable, o_hysteresis_enable, o_cmp1_pin, o_cmp1_tim_cap;
  logic o_brake_cmp2, o_sys_reset_req;
  int num_errors = 0;
  int comparisons = 0;
  acc_ctrl #(.POLL_DWELL(4)) acc_ctrl_inst (.i_clk_sys, .i_rstn, .i_wr, .i_idx, .i_wdata, .i_ridx, .o_rdata,
    .i_cmp1_raw, .i_cmp2_raw, .o_amp_enable, .o_pos_input_sel, .o_neg_input_gain_sel, .o_output_route_sel,
    .o_neg_ground, .o_internal_feedback_en, .o_amp_high_speed, .o_bias_enable, .o_bias_level_sel, .o_cmp2_ref_sel,
    .o_comparator1_enable, .o_comparator2_enable, .o_cmp1_route_sel, .o_cmp1_pos_sel, .o_cmp1_neg_sel,
    .o_hysteresis_enable, .o_cmp1_pin, .o_cmp1_tim_cap, .o_brake_cmp2, .o_sys_reset_req);
  always #2 i_clk_sys = ~i_clk_sys;
  task automatic wr(input logic [2:0] idx, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_idx <= idx;
    i_wdata <= d;
  endtask
  task automatic keys(input logic [2:0] idx);
    wr(idx, `ACC_FIRST_KEY);
    wr(idx, `ACC_SECOND_KEY);
  endtask
  task automatic settle();
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic rd(input logic [2:0] idx, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_ridx <= idx;
    repeat (2) @(posedge i_clk_sys);
    #1;
    d = o_rdata;
  endtask
  function automatic logic [1:0] next_slot(input logic [1:0] s);
    return (s == 2'h1) ? 2'h2 : (s == 2'h2) ? 2'h0 : 2'h1;
  endfunction
  task automatic poll_watch(output int n);
    logic [1:0] prev;
    prev = o_pos_input_sel;
    n = 0;
    repeat (40) begin
      @(posedge i_clk_sys);
      #1;
      if (o_pos_input_sel !== prev) begin
        n++;
        `CHK(o_pos_input_sel, next_slot(prev))
        prev = o_pos_input_sel;
      end
    end
  endtask
  task automatic t_defaults();
    logic [31:0] d;
    `CHK({o_pos_input_sel, o_neg_input_gain_sel, o_output_route_sel}, 7'h7F)
    `CHK({o_neg_ground, o_cmp2_ref_sel}, 3'h7)
    `CHK({o_amp_enable, o_comparator1_enable, o_comparator2_enable}, 3'h0)
    rd(`ACC_IDX_CTL_A, d);
    `CHK(d, `ACC_CTL_A_RST)
    rd(`ACC_IDX_CTL_B, d);
    `CHK(d, `ACC_CTL_B_RST)
  endtask
  task automatic t_locked();
    wr(`ACC_IDX_CTL_A, 32'h00000001);
    wr(`ACC_IDX_CTL_B, 32'h00000001);
    wr(`ACC_IDX_AMP_KEY, `ACC_SECOND_KEY);
    wr(`ACC_IDX_AMP_KEY, `ACC_FIRST_KEY);
    wr(`ACC_IDX_CTL_A, 32'h00000001);
    settle();
    `CHK({o_amp_enable, o_comparator1_enable}, 2'h0)
  endtask
  task automatic t_amp();
    logic [31:0] d;
    keys(`ACC_IDX_AMP_KEY);
    wr(`ACC_IDX_CTL_A, 32'h00000001);
    settle();
    `CHK({o_amp_enable, o_pos_input_sel, o_neg_input_gain_sel, o_output_route_sel}, 8'h80)
    for (int g = 3; g <= 6; g++) begin
      wr(`ACC_IDX_CTL_A, 32'h00000001 | (g << 8));
      settle();
      `CHK({o_neg_input_gain_sel, o_internal_feedback_en, o_neg_ground}, {g[2:0], 2'h3})
    end
    wr(`ACC_IDX_CTL_A, 32'h00111301);
    settle();
    `CHK({o_neg_ground, o_internal_feedback_en, o_amp_high_speed}, 3'h3)
    `CHK({o_bias_enable, o_bias_level_sel, o_cmp2_ref_sel}, 4'h8)
    wr(`ACC_IDX_CTL_A, 32'h00020001);
    settle();
    `CHK({o_cmp2_ref_sel, o_amp_high_speed}, 3'h6)
    `CHK(o_bias_level_sel, 1'b1)
    wr(`ACC_IDX_CTL_A, 32'h80000001);
    wr(`ACC_IDX_CTL_A, 32'h00000000);
    settle();
    `CHK(o_amp_enable, 1'b1)
    rd(`ACC_IDX_CTL_A, d);
    `CHK(d[31], 1'b1)
  endtask
  task automatic t_cmp();
    @(posedge i_clk_sys);
    i_cmp1_raw <= 1'b1;
    i_cmp2_raw <= 1'b1;
    keys(`ACC_IDX_REG_A);
    wr(`ACC_IDX_CTL_B, 32'h08000000);
    wr(`ACC_IDX_CTL_B, 32'h08010001);
    wr(`ACC_IDX_CFG_B, 32'h00000020);
    settle();
    `CHK({o_cmp1_pin, o_cmp1_tim_cap, o_brake_cmp2, o_sys_reset_req}, 4'hB)
    `CHK({o_comparator1_enable, o_comparator2_enable}, 2'h3)
    wr(`ACC_IDX_CTL_B, 32'h040100CB);
    settle();
    `CHK({o_cmp1_pin, o_cmp1_tim_cap, o_brake_cmp2, o_sys_reset_req}, 4'h5)
    `CHK({o_cmp1_pos_sel, o_cmp1_neg_sel, o_hysteresis_enable}, 5'h13)
    wr(`ACC_IDX_CTL_B, 32'h00000000);
    settle();
    `CHK({o_cmp1_pin, o_cmp1_tim_cap, o_brake_cmp2, o_sys_reset_req, o_comparator2_enable}, 5'h0)
  endtask
  task automatic t_poll();
    int n;
    keys(`ACC_IDX_AMP_KEY);
    wr(`ACC_IDX_CFG_A, 32'h00090009);
    settle();
    poll_watch(n);
    `CHK(n >= 6, 1'b1)
    wr(`ACC_IDX_CFG_A, 32'h00090001);
    settle();
    // the slot running at the write still ends its dwell
    settle();
    poll_watch(n);
    `CHK({n == 0, o_pos_input_sel}, 3'h5)
  endtask
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    settle();
    t_defaults();
    t_locked();
    t_amp();
    t_cmp();
    t_poll();
    test_done();
  end
endmodule
